/* File: core/egq_pkg.sv */
/*
  constants, register indices and types of the egress queue rate limit block.
  assumes a 25 MHz system clock and word-addressed AXI4-Lite access (byte address = index * 4).
*/
`default_nettype none
package egq_pkg;
  // ==========================================================
  // sizes and timing
  localparam int NUM_PORTS      = 4;
  localparam int NUM_QUEUES     = 3;
  localparam int NUM_LIMITS     = NUM_PORTS * NUM_QUEUES;
  localparam int AXI_AW         = 10;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int TICK_NS        = 1000;
  localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_RSVD_BB = 8'hBB;
  localparam logic [7:0] IDX_RSVD_BC = 8'hBC;
  localparam logic [7:0] IDX_RSVD_BD = 8'hBD;
  localparam logic [7:0] IDX_P1_Q0   = 8'hCB;
  localparam logic [7:0] IDX_P1_Q1   = 8'hCC;
  localparam logic [7:0] IDX_P1_Q2   = 8'hCD;
  localparam logic [7:0] IDX_P2_Q0   = 8'hDB;
  localparam logic [7:0] IDX_P2_Q1   = 8'hDC;
  localparam logic [7:0] IDX_P2_Q2   = 8'hDD;
  localparam logic [7:0] IDX_P3_Q0   = 8'hEB;
  localparam logic [7:0] IDX_P3_Q1   = 8'hEC;
  localparam logic [7:0] IDX_P3_Q2   = 8'hED;
  localparam logic [7:0] IDX_P4_Q0   = 8'hFB;
  localparam logic [7:0] IDX_P4_Q1   = 8'hFC;
  localparam logic [7:0] IDX_P4_Q2   = 8'hFD;
  localparam logic [7:0] IDX_MODE    = 8'h40;
  localparam logic [7:0] IDX_STATUS  = 8'h41;
  localparam logic [NUM_LIMITS*8-1:0] LIMIT_IDX_TBL = {
    IDX_P4_Q2, IDX_P4_Q1, IDX_P4_Q0, IDX_P3_Q2, IDX_P3_Q1, IDX_P3_Q0,
    IDX_P2_Q2, IDX_P2_Q1, IDX_P2_Q0, IDX_P1_Q2, IDX_P1_Q1, IDX_P1_Q0};
  // ==========================================================
  // fields and reset values
  localparam int         LIMIT_W        = 7;
  localparam logic [6:0] LIMIT_RST      = 7'h00;
  localparam int         MODE_QM_LSB    = 0;
  localparam int         MODE_SPD_LSB   = 8;
  localparam logic [11:0] MODE_RST      = 12'hF00;
  // ==========================================================
  // rate code table
  localparam logic [6:0] CODE_LINE_100  = 7'h64;
  localparam logic [6:0] CODE_LINE_10   = 7'h0A;
  localparam logic [6:0] CODE_SUB_LO    = 7'h65;
  localparam logic [6:0] CODE_SUB_HI    = 7'h73;
  localparam logic [6:0] CODE_SUB_BASE  = 7'h64;
  localparam int         SUB_STEP_KBPS  = 64;
  localparam int         KBPS_PER_MBPS  = 1000;
  localparam int         RATE_W         = 17;
  localparam int         CREDIT_W       = 25;
  localparam int         BYTE_MILLIBITS = 8000;
  localparam int         CREDIT_CAP     = 12_288_000;
  // ==========================================================
  // enumerations
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    QM_ONE  = 2'b00,
    QM_TWO  = 2'b01,
    QM_FOUR = 2'b10
  } egq_qmode_t;
  typedef enum logic [2:0] {
    RK_NONE   = 3'b000,
    RK_LIMIT  = 3'b001,
    RK_RSVD   = 3'b010,
    RK_MODE   = 3'b011,
    RK_STATUS = 3'b100
  } egq_kind_t;
endpackage
`default_nettype wire

/* File: core/egq_shaper.sv */
/*
  credit shaper for one egress queue: credit in millibits grows every
  microsecond by the rate in Kbps and falls by one byte per sent byte.
  assumes one byte pulse per transmitted byte and a one-microsecond tick.
*/
`timescale 1ns/100ps
`default_nettype none
module egq_shaper #(
  parameter int CREDIT_W = egq_pkg::CREDIT_W,
  parameter int CAP      = egq_pkg::CREDIT_CAP
) (
  input  wire logic       i_sys_clk,  // system clock
  input  wire logic       i_rst,      // synchronous reset, active high
  input  wire logic       i_tick,     // one-microsecond enable pulse
  input  wire logic [6:0] i_code,     // rate limit code
  input  wire logic       i_speed100, // 1: 100 Mbps, 0: 10 Mbps
  input  wire logic       i_exact,    // queue is the top one of its port
  input  wire logic       i_byte,     // one byte left this queue
  output logic            o_ok        // queue may transmit
);
  // ==========================================================
  // rate decode
  logic [egq_pkg::RATE_W-1:0] rate_kbps;
  logic                       unlimited;

  always_comb
  begin
    logic [6:0] line;
    line      = i_speed100 ? egq_pkg::CODE_LINE_100 : egq_pkg::CODE_LINE_10;
    rate_kbps = '0;
    unlimited = 1'b0;
    if (i_code == 7'h00 || i_code == line)
    begin
      unlimited = 1'b1;
    end
    else if (i_code < line)
    begin
      rate_kbps = egq_pkg::RATE_W'(i_code * egq_pkg::KBPS_PER_MBPS);
    end
    else if (i_code >= egq_pkg::CODE_SUB_LO && i_code <= egq_pkg::CODE_SUB_HI)
    begin
      rate_kbps = egq_pkg::RATE_W'((i_code - egq_pkg::CODE_SUB_BASE)
                                   * egq_pkg::SUB_STEP_KBPS);
    end
    else
    begin
      // codes with no table entry leave the queue unshaped
      unlimited = 1'b1;
    end
  end

  // ==========================================================
  // credit bucket
  logic signed [CREDIT_W-1:0] credit;
  logic signed [CREDIT_W:0]   next_credit;

  // every operand is signed, so an overdrawn credit widens as a negative
  // value instead of turning into a huge positive one
  always_comb
  begin
    next_credit = (CREDIT_W+1)'(credit);
    if (i_tick)
    begin
      next_credit = next_credit + $signed((CREDIT_W+1)'(rate_kbps));
    end
    if (i_byte)
    begin
      next_credit = next_credit - (CREDIT_W+1)'(egq_pkg::BYTE_MILLIBITS);
    end
    if (next_credit > (CREDIT_W+1)'(CAP))
    begin
      next_credit = (CREDIT_W+1)'(CAP);
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || unlimited || !i_exact)
    begin
      credit <= '0;
    end
    else
    begin
      credit <= next_credit[CREDIT_W-1:0];
    end
  end

  // a frame may start while credit is not negative; it then overdraws
  assign o_ok = unlimited || !i_exact || (credit >= 0);
endmodule
`default_nettype wire

/* File: core/egq_egress_limit_regs.sv */
/*
  egress queue rate limit registers of a four-port switch with a per-queue
  shaper and a per-port queue selector, reached over AXI4-Lite.
  assumes one synchronous clock domain; queue 3 and the ratio scheduler for
  lower queues live outside this block.
*/
// Register access over AXI4-Lite is this design's own decision.
// Functional notes
// - one limit register per queue, each port
// - queue 0 limit bits 6-0, bit7 zero
// - queue 1 limit bits 6-0, bit7 zero
// - queue 2 limit bits 6-0, bit7 zero
// - top queue in use of each port shaped to its coded rate
// - four queues: queue 0 lowest priority
// - two queues: queue 0 low priority
// - four queues: queue 1 second lowest
// - two queues: queue 1 high priority
// - four queues: queue 2 second highest
// - codes 1..line-1 select that many Mbps
// - zero or line rate means unshaped
// - codes 101-115 give 64 Kbps steps
// - only top queue gets exact rate
`timescale 1ns/100ps
`default_nettype none
module egq_egress_limit_regs #(
  parameter int NUM_PORTS  = egq_pkg::NUM_PORTS,
  parameter int NUM_QUEUES = egq_pkg::NUM_QUEUES
) (
  input  wire logic                      i_sys_clk,     // system clock, 25 MHz
  input  wire logic                      i_rst,         // synchronous reset, active high
  input  wire logic [egq_pkg::AXI_AW-1:0] i_awaddr,     // write address
  input  wire logic                      i_awvalid,     // write address valid
  output logic                           o_awready,     // write address ready
  input  wire logic [31:0]               i_wdata,       // write data
  input  wire logic [3:0]                i_wstrb,       // write byte strobes
  input  wire logic                      i_wvalid,      // write data valid
  output logic                           o_wready,      // write data ready
  output logic [1:0]                     o_bresp,       // write response
  output logic                           o_bvalid,      // write response valid
  input  wire logic                      i_bready,      // write response ready
  input  wire logic [egq_pkg::AXI_AW-1:0] i_araddr,     // read address
  input  wire logic                      i_arvalid,     // read address valid
  output logic                           o_arready,     // read address ready
  output logic [31:0]                    o_rdata,       // read data
  output logic [1:0]                     o_rresp,       // read response
  output logic                           o_rvalid,      // read data valid
  input  wire logic                      i_rready,      // read data ready
  input  wire logic [NUM_PORTS*NUM_QUEUES-1:0] i_pending, // queue holds a frame
  input  wire logic [NUM_PORTS*NUM_QUEUES-1:0] i_byte_sent, // byte left a queue
  output logic [NUM_PORTS*NUM_QUEUES-1:0] o_permit,     // shaper allows queue
  output logic [NUM_PORTS*2-1:0]         o_sel_queue,   // chosen queue per port
  output logic [NUM_PORTS-1:0]           o_sel_valid    // a queue is chosen
);
  localparam int NL = NUM_PORTS * NUM_QUEUES;

  // ==========================================================
  // functions
  function automatic egq_pkg::egq_kind_t decode(input logic [egq_pkg::AXI_AW-1:0] addr,
                                                output logic [3:0] slot);
    logic [7:0] idx;
    egq_pkg::egq_kind_t kind;
    idx  = addr[egq_pkg::AXI_AW-1:2];
    kind = egq_pkg::RK_NONE;
    slot = 4'h0;
    for (int i = 0; i < NL; i++)
    begin
      if (idx == egq_pkg::LIMIT_IDX_TBL[i*8 +: 8])
      begin
        kind = egq_pkg::RK_LIMIT;
        slot = 4'(i);
      end
    end
    if (idx == egq_pkg::IDX_RSVD_BB || idx == egq_pkg::IDX_RSVD_BC
        || idx == egq_pkg::IDX_RSVD_BD)
    begin
      kind = egq_pkg::RK_RSVD;
    end
    if (idx == egq_pkg::IDX_MODE)
    begin
      kind = egq_pkg::RK_MODE;
    end
    if (idx == egq_pkg::IDX_STATUS)
    begin
      kind = egq_pkg::RK_STATUS;
    end
    return kind;
  endfunction

  // queues in use; an illegal mode code falls back to one queue
  function automatic int queue_count(input logic [1:0] qm);
    int n;
    unique case (egq_pkg::egq_qmode_t'(qm))
      egq_pkg::QM_TWO:  n = 2;
      egq_pkg::QM_FOUR: n = 4;
      default:          n = 1;
    endcase
    return n;
  endfunction

  // ==========================================================
  // register storage
  logic [6:0]  limit [NL];
  logic [11:0] mode;
  logic        do_write;
  logic [3:0]  w_slot;
  egq_pkg::egq_kind_t w_kind;

  // ==========================================================
  // write channel: address and data are taken in either order
  logic                      aw_held;
  logic [egq_pkg::AXI_AW-1:0] aw_addr;
  logic                      w_held;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;

  // each channel parks one beat until its partner arrives; both stay shut
  // while a response waits, so only one write is ever under way
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  assign do_write  = aw_held && w_held && !o_bvalid;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= i_awaddr;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (i_wvalid && o_wready)
    begin
      w_held <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
  end

  always_comb
  begin
    w_kind = decode(aw_addr, w_slot);
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= egq_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= (w_kind == egq_pkg::RK_NONE) ? egq_pkg::RESP_SLVERR
                                               : egq_pkg::RESP_OKAY;
    end
    else if (i_bready)
    begin
      o_bvalid <= 1'b0;
    end
  end

  // limit fields hold 7 bits; bit 7 of the byte is dropped
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < NL; i++)
      begin
        limit[i] <= egq_pkg::LIMIT_RST;
      end
    end
    else if (do_write && w_kind == egq_pkg::RK_LIMIT && w_strb[0])
    begin
      limit[w_slot] <= w_data[6:0];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      mode <= egq_pkg::MODE_RST;
    end
    else if (do_write && w_kind == egq_pkg::RK_MODE)
    begin
      if (w_strb[0])
      begin
        mode[7:0] <= w_data[7:0];
      end
      if (w_strb[1])
      begin
        mode[11:8] <= w_data[11:8];
      end
    end
  end

  // ==========================================================
  // read channel
  logic [3:0]  r_slot;
  logic [31:0] r_data;
  egq_pkg::egq_kind_t r_kind;

  // data are captured with the address, so rvalid rises one edge later
  assign o_arready = !o_rvalid;

  always_comb
  begin
    r_kind = decode(i_araddr, r_slot);
    unique case (r_kind)
      egq_pkg::RK_LIMIT:  r_data = {25'h0, limit[r_slot]};
      egq_pkg::RK_MODE:   r_data = {20'h0, mode};
      egq_pkg::RK_STATUS: r_data = {{(32-NL){1'b0}}, o_permit};
      default:            r_data = 32'h0;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= egq_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_rvalid <= 1'b1;
      o_rdata  <= r_data;
      o_rresp  <= (r_kind == egq_pkg::RK_NONE) ? egq_pkg::RESP_SLVERR
                                               : egq_pkg::RESP_OKAY;
    end
    else if (i_rready)
    begin
      o_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // microsecond tick for the shapers
  logic [4:0] tick_cnt;
  logic       tick;

  // free-running divider: its phase is not tied to any write, so a new
  // limit may earn its first credit anywhere inside the first microsecond
  assign tick = (tick_cnt == 5'(egq_pkg::TICK_CYCLES - 1));

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || tick)
    begin
      tick_cnt <= '0;
    end
    else
    begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end

  // ==========================================================
  // shapers: one per queue of each port
  logic [NL-1:0] exact;
  logic [NL-1:0] in_use;

  // queue number equals its rank from the bottom in every mode, so the
  // top queue in use is queue_count - 1; with four queues that is queue 3,
  // which lies outside, and all of ours then run on the ratio scheduler
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      for (int q = 0; q < NUM_QUEUES; q++)
      begin
        in_use[p*NUM_QUEUES+q] = q < queue_count(mode[p*2 +: 2]);
        exact[p*NUM_QUEUES+q]  = q == queue_count(mode[p*2 +: 2]) - 1;
      end
    end
  end

  for (genvar g = 0; g < NL; g++)
  begin : g_shaper
    egq_shaper u_shaper (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_tick     (tick),
      .i_code     (limit[g]),
      .i_speed100 (mode[egq_pkg::MODE_SPD_LSB + g / NUM_QUEUES]),
      .i_exact    (exact[g]),
      .i_byte     (i_byte_sent[g]),
      .o_ok       (o_permit[g])
    );
  end

  // ==========================================================
  // per-port selection: highest-ranked pending queue the shaper allows
  // queues outside the port's mode never win, whatever they have pending
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_sel_queue <= '0;
      o_sel_valid <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        o_sel_valid[p]       <= 1'b0;
        o_sel_queue[p*2 +: 2] <= 2'h0;
        for (int q = 0; q < NUM_QUEUES; q++)
        begin
          if (i_pending[p*NUM_QUEUES+q] && in_use[p*NUM_QUEUES+q]
              && o_permit[p*NUM_QUEUES+q])
          begin
            o_sel_valid[p]        <= 1'b1;
            o_sel_queue[p*2 +: 2] <= 2'(q);
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/egq_regs_chk.sv */
/*
  port assertions for the egress limit register block.
  assumes it is bound to egq_egress_limit_regs.
*/
`timescale 1ns/100ps
`default_nettype none
module egq_regs_chk #(
  parameter int NUM_PORTS  = egq_pkg::NUM_PORTS,
  parameter int NUM_QUEUES = egq_pkg::NUM_QUEUES
) (
  input wire logic                              i_sys_clk,   // clock
  input wire logic                              i_rst,       // reset
  input wire logic                              i_awvalid,   // aw valid
  input wire logic                              o_awready,   // aw ready
  input wire logic                              i_wvalid,    // w valid
  input wire logic                              o_wready,    // w ready
  input wire logic [1:0]                        o_bresp,     // b resp
  input wire logic                              o_bvalid,    // b valid
  input wire logic                              i_bready,    // b ready
  input wire logic [egq_pkg::AXI_AW-1:0]        i_araddr,    // ar addr
  input wire logic                              i_arvalid,   // ar valid
  input wire logic                              o_arready,   // ar ready
  input wire logic [31:0]                       o_rdata,     // r data
  input wire logic [1:0]                        o_rresp,     // r resp
  input wire logic                              o_rvalid,    // r valid
  input wire logic                              i_rready,    // r ready
  input wire logic [NUM_PORTS*NUM_QUEUES-1:0]   i_pending,   // queue pending
  input wire logic [NUM_PORTS*NUM_QUEUES-1:0]   o_permit,    // shaper permit
  input wire logic [NUM_PORTS*2-1:0]            o_sel_queue, // chosen queue
  input wire logic [NUM_PORTS-1:0]              o_sel_valid  // choice valid
);
  // ==========================================================
  // helper state: read index and last pending/permit
  logic [7:0]                        ar_idx;
  logic [NUM_PORTS*NUM_QUEUES-1:0]   pend_q;
  logic [NUM_PORTS*NUM_QUEUES-1:0]   perm_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_arvalid && o_arready)
      ar_idx <= i_araddr[9:2];
  end
  always_ff @(posedge i_sys_clk)
  begin
    pend_q <= i_pending;
    perm_q <= o_permit;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // assertions
  chk_reset_state: assert property (disable iff (1'b0) i_rst |=>
    (&o_permit) && o_sel_valid == '0 && !o_bvalid && !o_rvalid)
    else $error("outputs not at reset state");
  chk_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read data dropped early");
  chk_wr_block: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  chk_rd_block: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
  chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##2 o_bvalid)
    else $error("write answer late");
  chk_limit_width: assert property (o_rvalid && ar_idx[7:4] >= 4'hB &&
    ar_idx[3:0] >= 4'hB && ar_idx[3:0] <= 4'hD |-> o_rdata[31:7] == '0)
    else $error("limit upper bits not zero");
  chk_sel_cause: assert property (o_sel_valid[0] |->
    pend_q[o_sel_queue[1:0]] && perm_q[o_sel_queue[1:0]])
    else $error("port 1 choice without cause");
  chk_err_data: assert property (o_rvalid && o_rresp == egq_pkg::RESP_SLVERR |-> o_rdata == '0)
    else $error("error read returned data");
  cover property (i_awvalid && o_awready && i_wvalid && o_wready);
  cover property (o_rvalid && o_rresp == egq_pkg::RESP_SLVERR);
  cover property (o_sel_valid[1] && o_sel_queue[3:2] == 2'h2);
endmodule
bind egq_egress_limit_regs egq_regs_chk #(.NUM_PORTS(NUM_PORTS), .NUM_QUEUES(NUM_QUEUES))
  u_chk (.i_sys_clk, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp,
  .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
  .i_rready, .i_pending, .o_permit, .o_sel_queue, .o_sel_valid);
`default_nettype wire

/* File: verification/egq_egress_limit_regs_bench.sv */
/*
  self-checking bench for the egress limit register block.
  assumes word-indexed register map and a 25 tick-cycle shaper.
*/
`timescale 1ns/100ps
`default_nettype none
module egq_egress_limit_regs_bench;
  logic        i_sys_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [9:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb, o_sel_valid;
  logic [11:0] i_pending, i_byte_sent, o_permit;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [7:0]  o_sel_queue;
  int          err_total, samples_checked;
  egq_egress_limit_regs uut (.i_sys_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pending,
    .i_byte_sent, .o_permit, .o_sel_queue, .o_sel_valid);
  // ==========================================================
  // helpers
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // shaper ticks needed to earn back one byte, 0 when unshaped
  function automatic int ticks(input logic [6:0] c, input bit fast);
    int k;
    k = 0;
    if (c >= 7'h65 && c <= 7'h73)
      k = (c - 100) * 64;
    else if (c != 7'h00 && c < (fast ? 100 : 10))
      k = c * 1000;
    return (k == 0) ? 0 : (8000 + k - 1) / k;
  endfunction
  // handshakes are sampled at the falling edge, where they are settled
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic a, w, b;
    @(posedge i_sys_clk);
    i_awaddr  <= {idx, 2'b00};
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    do
    begin
      @(negedge i_sys_clk);
      a = i_awvalid && o_awready;
      w = i_wvalid && o_wready;
      b = o_bvalid;
      r = o_bresp;
      @(posedge i_sys_clk);
      if (a)
        i_awvalid <= 1'b0;
      if (w)
        i_wvalid <= 1'b0;
    end while (!b);
    i_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a, v;
    @(posedge i_sys_clk);
    i_araddr  <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    do
    begin
      @(negedge i_sys_clk);
      a = i_arvalid && o_arready;
      v = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_sys_clk);
      if (a)
        i_arvalid <= 1'b0;
    end while (!v);
    i_rready <= 1'b0;
  endtask
  task automatic sel(input logic [11:0] p, input logic [7:0] q, input logic [3:0] vld);
    logic [7:0] g;
    @(posedge i_sys_clk);
    i_pending <= p;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    g = o_sel_queue;
    for (int k = 0; k < 4; k++)
      if (!vld[k])
        g[2*k +: 2] = 2'h0;
    chk({24'h0, g}, {24'h0, q});
    chk({28'h0, o_sel_valid}, {28'h0, vld});
  endtask
  task automatic sh(input int b, input logic [7:0] idx, input logic [6:0] c, input int t);
    logic [1:0] r;
    wr(idx, {25'h0, c}, r);
    @(posedge i_sys_clk);
    i_byte_sent <= 12'h001 << b;
    @(posedge i_sys_clk);
    i_byte_sent <= 12'h000;
    @(negedge i_sys_clk);
    chk({31'h0, o_permit[b]}, (t == 0) ? 32'h1 : 32'h0);
    if (t > 0)
    begin
      repeat ((t - 3) * 25 - 6) @(negedge i_sys_clk);
      chk({31'h0, o_permit[b]}, 32'h0);
      repeat (86) @(negedge i_sys_clk);
      chk({31'h0, o_permit[b]}, 32'h1);
    end
    wr(idx, 32'h0, r);
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    repeat (40000) @(posedge i_sys_clk);
    err_total++;
    finish_test;
  end
  initial
  begin
    logic [31:0] d;
    logic [31:0] v [12];
    logic [1:0]  r;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_pending, i_byte_sent} = '0;
    i_wstrb = 4'hF;
    i_rst = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    void'($urandom(19));
    for (int i = 0; i < 12; i++)
    begin
      rd(egq_pkg::LIMIT_IDX_TBL[i*8 +: 8], d, r);
      chk(d, 32'h0);
    end
    for (int i = 0; i < 3; i++)
    begin
      wr(egq_pkg::IDX_RSVD_BB + 8'(i), 32'hFFFF_FFFF, r);
      rd(egq_pkg::IDX_RSVD_BB + 8'(i), d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, egq_pkg::RESP_OKAY});
    end
    rd(8'h10, d, r);
    chk({30'h0, r}, {30'h0, egq_pkg::RESP_SLVERR});
    wr(8'h11, 32'h0, r);
    chk({30'h0, r}, {30'h0, egq_pkg::RESP_SLVERR});
    for (int i = 0; i < 12; i++)
    begin
      v[i] = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      wr(egq_pkg::LIMIT_IDX_TBL[i*8 +: 8], v[i], r);
    end
    for (int i = 0; i < 12; i++)
    begin
      rd(egq_pkg::LIMIT_IDX_TBL[i*8 +: 8], d, r);
      chk(d, {25'h0, v[i][6:0]});
    end
    // mid-run reset must clear the limit of P4 queue 2, the last one written
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(egq_pkg::IDX_P4_Q2, d, r);
    chk(d, 32'h0);
    wr(egq_pkg::IDX_MODE, 32'h0000_0FC9, r);
    sel(12'hFFF, 8'h09, 4'hF);
    sel(12'h012, 8'h05, 4'h3);
    sel(12'h249, 8'h00, 4'hF);
    rd(egq_pkg::IDX_MODE, d, r);
    chk(d, 32'h0000_0FC9);
    rd(egq_pkg::IDX_STATUS, d, r);
    chk(d, 32'h0000_0FFF);
    i_pending <= 12'h000;
    wr(egq_pkg::IDX_MODE, 32'h0000_0B04, r);
    sh(0, egq_pkg::IDX_P1_Q0, 7'h01, ticks(7'h01, 1'b1));
    sh(0, egq_pkg::IDX_P1_Q0, 7'h02, ticks(7'h02, 1'b1));
    sh(0, egq_pkg::IDX_P1_Q0, 7'h65, ticks(7'h65, 1'b1));
    sh(0, egq_pkg::IDX_P1_Q0, 7'h73, ticks(7'h73, 1'b1));
    d = 32'h65 + 32'($urandom_range(14));
    sh(0, egq_pkg::IDX_P1_Q0, d[6:0], ticks(d[6:0], 1'b1));
    sh(0, egq_pkg::IDX_P1_Q0, 7'h64, ticks(7'h64, 1'b1));
    sh(6, egq_pkg::IDX_P3_Q0, 7'h01, ticks(7'h01, 1'b0));
    sh(6, egq_pkg::IDX_P3_Q0, 7'h02, ticks(7'h02, 1'b0));
    sh(6, egq_pkg::IDX_P3_Q0, 7'h0A, ticks(7'h0A, 1'b0));
    sh(3, egq_pkg::IDX_P2_Q0, 7'h01, 0);
    sh(4, egq_pkg::IDX_P2_Q1, 7'h02, ticks(7'h02, 1'b1));
    finish_test;
  end
endmodule
`default_nettype wire
